// >>> logic/icfe_pkg.sv
/*
 * Constants, types and register map of the interrupt flag and enable bank.
 * Assumes a 25 MHz system clock, an APB master with 32-bit data, and a CPU
 * core that takes one vector at a time and acknowledges it with a pulse.
 */
// Summary of operation
// RULE1 - First primary register: bit 2 enables pin 1, bit 1 enables pin 0, bit 0 is the global enable.
// RULE2 - Second primary register: flags adc 7, group1 6, group0 5, comparator1 4, enables at 3 to 0.
// RULE3 - Third primary register: flags group3 7, timebase1 6, timebase0 5, group2 4, enables at 3 to 0.
// RULE4 - Fourth primary register: flags group5 7, group4 6, pin 3 at 5, pin 2 at 4, enables at 3 to 0. No group sets bit 7 here; only software writes it.
// RULE5 - First shared register: std timer0 A 7, P 6, periodic timer0 A 5, P 4, enables at 3 to 0.
// RULE6 - Second shared register: same layout for std timer1 and periodic timer1.
// RULE7 - Third shared register: periodic timer2 A flag 5, P flag 4, A enable 1, P enable 0 only.
// RULE8 - Unimplemented bit positions read as zero and ignore writes.
// RULE9 - Fourth shared register: sync serial 7, second serial 6, eeprom write 5, low voltage 4, enables 3 to 0.
// RULE10 - Fifth shared register: std timer2 A 7, P 6, periodic timer3 A 5, P 4, enables 3 to 0.
// RULE11 - A flag reads 1 while a request is pending and software may read and write it.
// RULE12 - An enable of 1 lets its source interrupt, 0 blocks it; all bits reset to 0.
// RULE13 - With the global enable clear no interrupt is taken at all.
// RULE14 - A flag is still set on its event while its enable is 0, but no vector results.
// RULE15 - Taking an interrupt clears the global enable while flags keep being recorded.
// RULE16 - A group flag is set while any sub-request of its shared register is flagged and enabled.
package icfe_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    // Four primary registers first, then the five shared registers
    localparam int NUM_REGS = 9;
    localparam logic [11:0] REG_OFFSET [NUM_REGS] = '{
        12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020};
    localparam logic [11:0] STATUS_OFFSET = 12'h024;
    localparam logic [11:0] MASK_OFFSET = 12'h028;
    localparam logic [7:0] REG_IMPL [NUM_REGS] = '{
        8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h33, 8'hff, 8'hff}; // see RULE7 RULE8
    localparam logic [7:0] REG_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int GLOBAL_EN_BIT = 0;
    localparam int FLAG_LSB = 4;
    // Shared register n sits at index SHARED_BASE + n, clear of the primary ones
    localparam int SHARED_BASE = 4;
    localparam int NUM_GROUPS = 5;
    localparam int NUM_PRIMARY = 15;
    localparam int VEC_W = 4;
    localparam int STAT_TAKEN_BIT = 0;
    localparam int STAT_BLOCKED_BIT = 1;
    localparam int STAT_W = 2;
    localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

    typedef struct packed {
        logic [7:0] bits;
    } icfe_flag_s;

endpackage

// >>> logic/icfe_flag_reg.sv
/*
 * One 8-bit flag and enable register: software writes, hardware sets and
 * clears. Assumes set and clear strobes are synchronous single-cycle terms.
 */
`timescale 1ns/1ps
module icfe_flag_reg import icfe_pkg::*; #(
    parameter logic [7:0] IMPL_MASK = 8'hff
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Access
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] set_i,
    input wire logic [7:0] clr_i,
    output logic [7:0] value_o
);

    icfe_flag_s st;
    icfe_flag_s next_st;

    // ----------------------------------------------------------------
    // Update: set beats both software write and hardware clear
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (wr_i) begin
            next_st.bits = wdata_i; // see RULE11
        end
        next_st.bits = ((next_st.bits & ~clr_i) | set_i) & IMPL_MASK; // see RULE8
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st.bits <= REG_RESET; // see RULE12
        end else begin
            st <= next_st;
        end
    end

    assign value_o = st.bits;

endmodule

// >>> logic/icfe_prio_enc.sv
/*
 * Fixed-priority encoder: the lowest requesting index wins.
 * Assumes requests are already gated by their enables.
 */
`timescale 1ns/1ps
module icfe_prio_enc #(
    parameter int N = 15,
    parameter int W = 4
) (
    // Requests
    input wire logic [N-1:0] req_i,
    // Winner
    output logic valid_o,
    output logic [W-1:0] index_o
);

    always_comb begin
        valid_o = |req_i;
        index_o = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req_i[i]) begin
                index_o = W'(i);
            end
        end
    end

endmodule

// >>> logic/icfe_top.sv
/*
 * Interrupt flag and enable register bank with APB access, multi-function
 * grouping, priority vector selection and a summary interrupt line.
 * Assumes all event inputs are one-cycle pulses synchronous to clk_i and
 * that the CPU pulses irq_ack_i once when it takes the vector on vector_o.
 */
`timescale 1ns/1ps
module icfe_top import icfe_pkg::*; #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Direct interrupt sources
    input wire logic [3:0] ext_pin_evt_i,
    input wire logic [1:0] comparator_evt_i,
    input wire logic adc_done_evt_i,
    input wire logic [1:0] timebase_evt_i,
    // Shared sources, four per shared register
    input wire logic [4*NUM_GROUPS-1:0] shared_evt_i,
    // CPU side
    input wire logic irq_ack_i,
    output logic irq_req_o,
    output logic [VEC_W-1:0] vector_o,
    // Summary interrupt
    output logic irq_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
        logic irq_req;
        logic [VEC_W-1:0] vector;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        logic irq;
    } icfe_state_s;

    icfe_state_s st;
    icfe_state_s next_st;

    logic [7:0] reg_val [NUM_REGS];
    logic [7:0] reg_set [NUM_REGS];
    logic [7:0] reg_clr [NUM_REGS];
    logic [3:0] reg_en [NUM_REGS];
    logic [NUM_REGS-1:0] reg_wr;
    logic [NUM_GROUPS-1:0] group_any;
    logic [NUM_PRIMARY-1:0] prim_flag;
    logic [NUM_PRIMARY-1:0] prim_en;
    logic [NUM_PRIMARY-1:0] prim_clr;
    logic global_en;
    logic win_valid;
    logic [VEC_W-1:0] win_index;
    logic access;
    logic take;
    logic blocked_evt;
    logic rd_status;

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    generate
        for (genvar k = 0; k < NUM_REGS; k++) begin : g_reg
            icfe_flag_reg #(
                .IMPL_MASK(REG_IMPL[k])
            ) u_reg (
                .clk_i(clk_i),
                .reset_n_i(reset_n_i),
                .wr_i(reg_wr[k]),
                .wdata_i(pwdata_i[7:0]),
                .set_i(reg_set[k]),
                .clr_i(reg_clr[k]),
                .value_o(reg_val[k])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Group requests and primary view
    // ----------------------------------------------------------------
    always_comb begin
        for (int n = 0; n < NUM_GROUPS; n++) begin
            // A group stays raised while one of its sub-requests is live
            group_any[n] = |(reg_val[SHARED_BASE+n][7:4] & reg_val[SHARED_BASE+n][3:0]); // see RULE16
        end
    end

    // Pin enables share the first register with the global enable
    assign global_en = reg_val[0][GLOBAL_EN_BIT]; // see RULE1
    assign prim_flag = {reg_val[3][7:4], reg_val[2][7:4], reg_val[1][7:4], reg_val[0][6:4]}; // see RULE2
    assign prim_en = {reg_val[3][3:0], reg_val[2][3:0], reg_val[1][3:0], reg_val[0][3:1]}; // see RULE3

    icfe_prio_enc #(
        .N(NUM_PRIMARY),
        .W(VEC_W)
    ) u_prio (
        .req_i(prim_flag & prim_en), // see RULE12
        .valid_o(win_valid),
        .index_o(win_index)
    );

    // ----------------------------------------------------------------
    // Set and clear terms
    // ----------------------------------------------------------------
    // A take is only honoured while the global enable still stands
    assign take = irq_ack_i & st.irq_req & global_en; // see RULE13
    assign prim_clr = take ? NUM_PRIMARY'(15'h0001 << st.vector) : '0;

    always_comb begin
        for (int k = 0; k < NUM_REGS; k++) begin
            reg_set[k] = 8'h00;
            reg_clr[k] = 8'h00;
        end
        reg_set[0] = {1'b0, comparator_evt_i[0], ext_pin_evt_i[1], ext_pin_evt_i[0], 4'h0};
        reg_set[1] = {adc_done_evt_i, group_any[1], group_any[0], comparator_evt_i[1], 4'h0}; // see RULE2
        reg_set[2] = {group_any[3], timebase_evt_i[1], timebase_evt_i[0], group_any[2], 4'h0}; // see RULE3
        // Group 5 has no shared register in this bank; software alone drives it
        reg_set[3] = {1'b0, group_any[4], ext_pin_evt_i[3], ext_pin_evt_i[2], 4'h0}; // see RULE4
        for (int n = 0; n < NUM_GROUPS; n++) begin
            // Timer, serial, eeprom and low-voltage sources land in bits 7 to 4
            reg_set[SHARED_BASE+n] = {shared_evt_i[4*n +: 4], 4'h0}; // see RULE5 RULE6 RULE7 RULE9 RULE10
        end
        // Taking clears the served flag and the global enable
        reg_clr[0] = {1'b0, prim_clr[2:0], 3'b000, take}; // see RULE15
        reg_clr[1] = {prim_clr[6:3], 4'h0};
        reg_clr[2] = {prim_clr[10:7], 4'h0};
        reg_clr[3] = {prim_clr[14:11], 4'h0};
    end

    // ----------------------------------------------------------------
    // Events on disabled sources
    // ----------------------------------------------------------------
    always_comb begin
        blocked_evt = 1'b0;
        for (int k = 0; k < NUM_REGS; k++) begin
            reg_en[k] = (k == 0) ? {1'b1, reg_val[0][3:1]} : reg_val[k][3:0];
            // Flag is still recorded, the event only lands in status
            blocked_evt = blocked_evt | (|(reg_set[k][7:4] & ~reg_en[k][3:0] & REG_IMPL[k][7:4])); // see RULE14
        end
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    // Zero wait state: pready is raised at the setup edge
    assign access = psel_i & penable_i & st.pready;
    assign rd_status = access & ~pwrite_i & (paddr_i == ADDR_W'(STATUS_OFFSET));

    always_comb begin
        for (int k = 0; k < NUM_REGS; k++) begin
            // Byte lane 0 carries the whole register; other lanes are ignored
            reg_wr[k] = access & pwrite_i & pstrb_i[0] & (paddr_i == ADDR_W'(REG_OFFSET[k])); // see RULE11
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic hit;
        hit = 1'b0;
        next_st = st;
        next_st.pready = psel_i & ~penable_i;
        if (psel_i & ~penable_i) begin
            next_st.prdata = 32'h0000_0000;
            for (int k = 0; k < NUM_REGS; k++) begin
                if (paddr_i == ADDR_W'(REG_OFFSET[k])) begin
                    hit = 1'b1;
                    next_st.prdata = {24'h00_0000, reg_val[k]}; // see RULE8
                end
            end
            if (paddr_i == ADDR_W'(STATUS_OFFSET)) begin
                hit = 1'b1;
                next_st.prdata = {30'h0000_0000, st.status};
            end
            if (paddr_i == ADDR_W'(MASK_OFFSET)) begin
                hit = 1'b1;
                next_st.prdata = {30'h0000_0000, st.mask};
            end
            next_st.pslverr = ~hit;
        end else if (!next_st.pready) begin
            next_st.pslverr = 1'b0;
        end
        if (access & pwrite_i & pstrb_i[0] & (paddr_i == ADDR_W'(MASK_OFFSET))) begin
            next_st.mask = pwdata_i[STAT_W-1:0];
        end
        // Only the bits already returned are cleared, so a new event survives
        if (rd_status) begin
            next_st.status = st.status & ~st.prdata[STAT_W-1:0];
        end
        next_st.status[STAT_TAKEN_BIT] = next_st.status[STAT_TAKEN_BIT] | take;
        next_st.status[STAT_BLOCKED_BIT] = next_st.status[STAT_BLOCKED_BIT] | blocked_evt;
        next_st.irq = |(next_st.status & next_st.mask);
        // Request drops the cycle after a take through ~take, as the global enable only falls at the same edge
        next_st.irq_req = global_en & win_valid & ~take; // see RULE13
        next_st.vector = win_index;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st.pready <= 1'b0;
            st.prdata <= 32'h0000_0000;
            st.pslverr <= 1'b0;
            st.irq_req <= 1'b0;
            st.vector <= '0;
            st.status <= STAT_RESET;
            st.mask <= STAT_RESET;
            st.irq <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pready_o = st.pready;
    assign prdata_o = st.prdata;
    assign pslverr_o = st.pslverr;
    assign irq_req_o = st.irq_req;
    assign vector_o = st.vector;
    assign irq_o = st.irq;

endmodule

// >>> dv/icfe_top_asserts.sv
/* Checker for the interrupt flag and enable bank, bound to icfe_top.
   Assumes the zero-wait APB slave and flop outputs of the bank. */
`timescale 1ns/1ps
module icfe_top_asserts import icfe_pkg::*; #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    // Sources and CPU
    input wire logic [3:0] ext_pin_evt_i,
    input wire logic [1:0] comparator_evt_i,
    input wire logic adc_done_evt_i,
    input wire logic [1:0] timebase_evt_i,
    input wire logic [4*NUM_GROUPS-1:0] shared_evt_i,
    input wire logic irq_ack_i,
    input wire logic irq_req_o,
    input wire logic [VEC_W-1:0] vector_o,
    input wire logic irq_o
);
    default clocking dflt @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_take;
        irq_ack_i && irq_req_o;
    endsequence
    a_ready_next: assert property (s_setup |=> pready_o)
        else $error("No ready after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("Ready held too long");
    a_err_unmapped: assert property (s_setup and paddr_i > MASK_OFFSET |=> pslverr_o && prdata_o == 32'h0)
        else $error("Unmapped access not refused");
    a_err_mapped: assert property (s_setup and paddr_i <= MASK_OFFSET && paddr_i[1:0] == 2'h0 |=> !pslverr_o)
        else $error("Mapped access refused");
    a_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h0)
        else $error("Upper read bits not zero");
    a_take_drop: assert property (s_take |=> !irq_req_o)
        else $error("Request kept after take");
    a_stay_off: assert property (s_take ##1 (!psel_i)[*3] |-> !irq_req_o)
        else $error("Request while global enable off");
    a_vec_range: assert property (irq_req_o |-> vector_o < 4'(NUM_PRIMARY))
        else $error("Vector out of range");
endmodule
bind icfe_top icfe_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .ext_pin_evt_i(ext_pin_evt_i),
    .comparator_evt_i(comparator_evt_i), .adc_done_evt_i(adc_done_evt_i), .timebase_evt_i(timebase_evt_i),
    .shared_evt_i(shared_evt_i), .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .vector_o(vector_o), .irq_o(irq_o));

// >>> dv/icfe_cpu_model.sv
/* Behavioural CPU core that takes vectors from the bank.
   Assumes irq_req_i and vector_i are flops on the same clock. */
`timescale 1ns/1ps
module icfe_cpu_model import icfe_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Bank side
    input wire logic irq_req_i,
    input wire logic [VEC_W-1:0] vector_i,
    output logic irq_ack_o,
    // Bench control
    input wire logic ack_en_i,
    input wire logic [3:0] delay_i,
    output logic [VEC_W-1:0] last_vec_o,
    output logic [7:0] takes_o
);
    logic [3:0] wait_cnt;
    // A slow core lets the request stand delay_i + 1 cycles before the take
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_cnt <= 4'h0;
            irq_ack_o <= 1'b0;
            last_vec_o <= '0;
            takes_o <= 8'h0;
        end else begin
            irq_ack_o <= 1'b0;
            wait_cnt <= irq_req_i ? wait_cnt + 4'h1 : 4'h0;
            if (irq_req_i && ack_en_i && !irq_ack_o && wait_cnt >= delay_i) begin
                irq_ack_o <= 1'b1;
            end
            if (irq_ack_o && irq_req_i) begin
                last_vec_o <= vector_i;
                takes_o <= takes_o + 8'h1;
            end
        end
    end
endmodule

// >>> dv/test_interrupt_flag_enable_regs.sv
/* Self-checking bench for the interrupt flag and enable bank.
   Assumes the APB timing of the bank and the register map of the package. */
`timescale 1ns/1ps
module test_interrupt_flag_enable_regs import icfe_pkg::*; ();
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, ack_en = 1'b0, err;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, prdata_o, rd;
    logic [28:0] evt = '0;
    logic [3:0] delay = 4'h0;
    logic pready_o, pslverr_o, irq_ack_i, irq_req_o, irq_o;
    logic [VEC_W-1:0] vector_o, last_vec;
    logic [7:0] takes;
    int n_errors = 0, checks = 0;
    int mdl [NUM_REGS];
    always #20 clk_i = ~clk_i;
    icfe_top DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf), .pready_o(pready_o),
        .prdata_o(prdata_o), .pslverr_o(pslverr_o), .ext_pin_evt_i(evt[3:0]), .comparator_evt_i(evt[5:4]),
        .adc_done_evt_i(evt[6]), .timebase_evt_i(evt[8:7]), .shared_evt_i(evt[28:9]), .irq_ack_i(irq_ack_i),
        .irq_req_o(irq_req_o), .vector_o(vector_o), .irq_o(irq_o));
    icfe_cpu_model cpu (.clk_i(clk_i), .reset_n_i(reset_n_i), .irq_req_i(irq_req_o), .vector_i(vector_o),
        .irq_ack_o(irq_ack_i), .ack_en_i(ack_en), .delay_i(delay), .last_vec_o(last_vec), .takes_o(takes));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) @(posedge clk_i);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic pulse(input int i);
        @(posedge clk_i);
        evt <= 29'h1 << i;
        @(posedge clk_i);
        evt <= '0;
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(6));
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (int k = 0; k < NUM_REGS; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk(rd, 32'h0);
        end
        // Shared enables stay 0 and global stays off, so reads are pure storage
        for (int k = 0; k < NUM_REGS; k++) begin
            mdl[k] = $urandom & (k == 0 ? 32'h7e : (k < 4 ? 32'hff : 32'hf0));
            apb(1'b1, 12'(4 * k), mdl[k]);
            mdl[k] = mdl[k] & REG_IMPL[k];
        end
        for (int k = 0; k < NUM_REGS; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk(rd, mdl[k]);
            apb(1'b1, 12'(4 * k), 32'h0);
        end
        apb(1'b0, 12'h040, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, 12'h018, 32'hff);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h33);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h10);
        apb(1'b1, 12'h018, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h014, 32'h08);
        pulse(16);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h88);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h40);
        apb(1'b1, 12'h014, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        delay <= 4'($urandom % 8);
        ack_en <= 1'b1;
        apb(1'b1, 12'h000, 32'h03);
        pulse(0);
        repeat (30) @(posedge clk_i);
        chk(last_vec, 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h02);
        apb(1'b1, MASK_OFFSET, 32'h3);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 32'h1);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        // Group flags raised earlier with their group enables off count as blocked events
        chk(rd, 32'h3);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 32'h0);
        apb(1'b1, 12'h000, 32'h01);
        pulse(1);
        repeat (4) @(posedge clk_i);
        chk(irq_req_o, 32'h0);
        chk(irq_o, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h21);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, 12'h000, 32'h26);
        repeat (4) @(posedge clk_i);
        chk(irq_req_o, 32'h0);
        apb(1'b1, 12'h000, 32'h27);
        repeat (30) @(posedge clk_i);
        chk(last_vec, 32'h1);
        chk(takes, 32'h2);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h06);
        wrap_up();
    end
endmodule
